// [logic/cio_map.vh]
// Purpose: Constants for the configurable io cell and its APB map
// Assumes: 32-bit APB data, byte addresses, one word per register
// Notes:   Included by every design file of the cell
`ifndef CIO_MAP_VH
`define CIO_MAP_VH

// Register byte addresses
`define CIO_ADDR_CTRL      4'h0
`define CIO_ADDR_INIT      4'h4
`define CIO_ADDR_INV       4'h8
`define CIO_ADDR_STATUS    4'hc
`define CIO_ADDR_W         4

// Control register fields
`define CIO_CTRL_DONE      0
`define CIO_CTRL_IN_SEL    1
`define CIO_CTRL_OUT_SEL   2
`define CIO_CTRL_OE_SEL    3
`define CIO_CTRL_DLY_SEL   4
`define CIO_CTRL_PULLUP    5
`define CIO_CTRL_PULLDN    6
`define CIO_CTRL_KEEP      7
`define CIO_CTRL_LATCH_LO  8
`define CIO_CTRL_LATCH_HI  10
`define CIO_CTRL_W         11
`define CIO_CTRL_RST       11'h000

// Init register: two bits per element
`define CIO_INIT_W         6
`define CIO_INIT_RST       6'h00
`define CIO_INIT_SYNC_SET  2'h0
`define CIO_INIT_SYNC_CLR  2'h1
`define CIO_INIT_ASYNC_SET 2'h2
`define CIO_INIT_ASYNC_CLR 2'h3

// Inversion register fields
`define CIO_INV_OUT        0
`define CIO_INV_OE         1
`define CIO_INV_CLK        2
`define CIO_INV_SR         3
`define CIO_INV_CE_LO      4
`define CIO_INV_CE_HI      6
`define CIO_INV_W          7
`define CIO_INV_RST        7'h00

// Status register width
`define CIO_STAT_W         6

// Element indices
`define CIO_EL_IN          0
`define CIO_EL_OUT         1
`define CIO_EL_OE          2
`define CIO_EL_N           3

// Boundary-scan cell positions and init field width
`define CIO_BS_PAD         0
`define CIO_BS_OUT         1
`define CIO_BS_OE          2
`define CIO_BS_W           3
`define CIO_INIT_FW        2

`endif

// [logic/cio_store.v]
// Purpose: One storage element of the io cell, flip-flop or latch
// Assumes: Element clock is a sampled level on the system clock
// Notes:   Async init is modelled as a combinational override of q
`timescale 1ns/1ps
`include "cio_map.vh"

module cio_store (
   input  wire       sys_clk,    // System clock
   input  wire       rst,        // Async reset, active high
   input  wire       d,          // Data in
   input  wire       clk_lvl,    // Element clock level, polarity fixed
   input  wire       clk_rise,   // Element clock rising edge
   input  wire       ce,         // Clock enable, polarity fixed
   input  wire       init,       // Shared init control, polarity fixed
   input  wire       latch_mode, // 1 latch, 0 flip-flop
   input  wire [1:0] init_mode,  // Init behaviour
   output wire       q           // Element output
);

   reg  q_reg;
   reg  q_next;
   wire is_async;
   wire init_val;
   wire load_evt;

   assign is_async = (init_mode == `CIO_INIT_ASYNC_SET) ||
                     (init_mode == `CIO_INIT_ASYNC_CLR);
   assign init_val = (init_mode == `CIO_INIT_SYNC_SET) ||
                     (init_mode == `CIO_INIT_ASYNC_SET);
   // Latch follows the level, flip-flop only the edge
   assign load_evt = latch_mode ? clk_lvl : clk_rise; // [R5] [R15]

   always @* begin
      q_next = q_reg;
      if (init && is_async) begin
         q_next = init_val; // [R7]
      end else if (load_evt && ce) begin // [R6]
         if (init) begin
            q_next = init_val; // [R16]
         end else begin
            q_next = d;
         end
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         q_reg <= 1'b0;
      end else begin
         q_reg <= q_next;
      end
   end

   // Async forms act at once, without waiting for an edge
   assign q = (init && is_async) ? init_val : q_reg; // [R7]

endmodule

// [logic/cio_cell.v]
// Purpose: Configurable io cell between user logic and one pad
// Assumes: All inputs synchronous to sys_clk; APB register access
// Notes:   Pull and keeper outputs steer weak pad drivers outside
// Contract
// [R1] Pad drive and every control input have their own inversion bit.
// [R2] Before configuration the pad driver stays off.
// [R3] Before configuration pull-down and keeper are off, pull-up optional.
// [R4] The mode pins alone decide the pre-configuration pull-up.
// [R5] Each storage element works as flip-flop or latch.
// [R6] One shared element clock, a separate enable per element.
// [R7] One init control reaches all elements, each with its own form.
// [R8] Pad data reaches user logic directly or via the input element.
// [R9] An optional delay on the input element data removes hold time.
// [R10] Pad data comes from user logic directly or via the out element.
// [R11] Driver enable comes directly or via its own element.
// [R12] The keeper weakly holds the last level seen on the pad.
// [R13] After configuration, pull-up and pull-down are chosen per pin.
// [R14] The cell is one stage of a boundary-scan chain.
// [R15] A latch passes data while its clock is active, else holds.
// [R16] Sync init needs the enable and beats data loading.
`timescale 1ns/1ps
`include "cio_map.vh"

module cio_cell (
   input  wire        sys_clk,       // System clock, 20 MHz
   input  wire        rst,           // Async reset, active high
   // APB slave
   input  wire        psel,          // Slave select
   input  wire        penable,       // Access phase
   input  wire        pwrite,        // Write when high
   input  wire [31:0] paddr,         // Byte address
   input  wire [31:0] pwdata,        // Write data
   output wire        pready,        // Always ready
   output reg  [31:0] prdata,        // Read data, registered
   output wire        pslverr,       // Unmapped address
   // User side
   input  wire        user_clk,      // Shared element clock level
   input  wire [2:0]  user_ce,       // Enables: input, output, oe
   input  wire        user_init,     // Shared init control
   input  wire        user_out,      // Data toward pad
   input  wire        user_oe,       // Driver enable, high drives
   output wire        user_in,       // Data from pad
   // Configuration mode pins
   input  wire        mode_pullup,   // Pre-config pull-up request
   // Pad side
   input  wire        pad_in,        // Level seen on the pad
   output wire        pad_out,       // Level driven onto the pad
   output wire        pad_oe_n,      // Low while the pad is driven
   output wire        pad_pullup,    // Pull-up resistor on
   output wire        pad_pulldown,  // Pull-down resistor on
   output wire        pad_keep_en,   // Keeper on
   output wire        pad_keep_val,  // Level the keeper holds
   // Boundary scan
   input  wire        bs_extest,     // Scan cells own the pad
   input  wire        bs_capture,    // Capture pad state
   input  wire        bs_shift,      // Shift the chain
   input  wire        bs_update,     // Update held values
   input  wire        bs_tdi,        // Serial in
   output wire        bs_tdo         // Serial out, registered
);

   // Registers
   reg  [`CIO_CTRL_W-1:0] ctrl_reg;
   reg  [`CIO_INIT_W-1:0] init_reg;
   reg  [`CIO_INV_W-1:0]  inv_reg;
   reg                    dly_reg;
   reg                    clk_prev_reg;
   reg                    keep_reg;
   reg  [`CIO_BS_W-1:0]   bs_shift_reg;
   reg  [`CIO_BS_W-1:0]   bs_hold_reg;
   reg  [`CIO_BS_W-1:0]   bs_shift_next;
   reg  [31:0]            prdata_next;

   wire                   cfg_done;
   wire                   apb_setup;
   wire                   apb_wr;
   wire                   addr_ok;
   wire [`CIO_ADDR_W-1:0] addr_lo;
   wire                   clk_lvl;
   wire                   clk_rise;
   wire                   init_lvl;
   wire [2:0]             ce_lvl;
   wire [2:0]             el_d;
   wire [2:0]             el_q;
   wire                   in_data;
   wire                   out_sel;
   wire                   oe_sel;
   wire                   drv_out;
   wire                   drv_en;
   wire                   drive_on;
   wire [`CIO_STAT_W-1:0] status;

   assign cfg_done = ctrl_reg[`CIO_CTRL_DONE];

   // APB decode; zero wait states
   assign addr_lo   = paddr[`CIO_ADDR_W-1:0];
   assign addr_ok   = (paddr[31:`CIO_ADDR_W] == 28'h0000000) &&
                      ((addr_lo == `CIO_ADDR_CTRL) ||
                       (addr_lo == `CIO_ADDR_INIT) ||
                       (addr_lo == `CIO_ADDR_INV)  ||
                       (addr_lo == `CIO_ADDR_STATUS));
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite && addr_ok;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !addr_ok;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `CIO_CTRL_RST;
         init_reg <= `CIO_INIT_RST;
         inv_reg  <= `CIO_INV_RST;
      end else if (apb_wr) begin
         case (addr_lo)
            `CIO_ADDR_CTRL: begin
               ctrl_reg <= pwdata[`CIO_CTRL_W-1:0];
            end
            `CIO_ADDR_INIT: begin
               init_reg <= pwdata[`CIO_INIT_W-1:0];
            end
            `CIO_ADDR_INV: begin
               inv_reg <= pwdata[`CIO_INV_W-1:0];
            end
            default: begin
               ctrl_reg <= ctrl_reg;
            end
         endcase
      end
   end

   // Read data is fetched in the setup cycle, ready in the access cycle
   always @* begin
      prdata_next = prdata;
      if (apb_setup) begin
         prdata_next = 32'h00000000;
         case (addr_lo)
            `CIO_ADDR_CTRL: begin
               prdata_next[`CIO_CTRL_W-1:0] = ctrl_reg;
            end
            `CIO_ADDR_INIT: begin
               prdata_next[`CIO_INIT_W-1:0] = init_reg;
            end
            `CIO_ADDR_INV: begin
               prdata_next[`CIO_INV_W-1:0] = inv_reg;
            end
            `CIO_ADDR_STATUS: begin
               prdata_next[`CIO_STAT_W-1:0] = status;
            end
            default: begin
               prdata_next = 32'h00000000;
            end
         endcase
         if (!addr_ok) begin
            prdata_next = 32'h00000000;
         end
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else begin
         prdata <= prdata_next;
      end
   end

   // Control polarity, each bit independent
   assign clk_lvl  = user_clk ^ inv_reg[`CIO_INV_CLK]; // [R1]
   assign init_lvl = user_init ^ inv_reg[`CIO_INV_SR]; // [R1]
   assign ce_lvl   = user_ce ^ inv_reg[`CIO_INV_CE_HI:`CIO_INV_CE_LO]; // [R1]

   // Element clock edge found against the previous sample
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clk_prev_reg <= 1'b0;
      end else begin
         clk_prev_reg <= clk_lvl;
      end
   end
   assign clk_rise = clk_lvl && !clk_prev_reg; // [R6]

   // One cycle data delay, lines up with the edge detector's lag
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dly_reg <= 1'b0;
      end else begin
         dly_reg <= pad_in;
      end
   end
   assign in_data = ctrl_reg[`CIO_CTRL_DLY_SEL] ? dly_reg : pad_in; // [R9]

   assign el_d[`CIO_EL_IN]  = in_data;
   assign el_d[`CIO_EL_OUT] = user_out;
   assign el_d[`CIO_EL_OE]  = user_oe;

   // Three elements, one clock, one init, separate enables
   genvar gi;
   generate
      for (gi = 0; gi < `CIO_EL_N; gi = gi + 1) begin : g_el
         cio_store u_store (
            .sys_clk    (sys_clk),
            .rst        (rst),
            .d          (el_d[gi]),
            .clk_lvl    (clk_lvl),
            .clk_rise   (clk_rise),
            .ce         (ce_lvl[gi]),
            .init       (init_lvl),
            .latch_mode (ctrl_reg[`CIO_CTRL_LATCH_LO + gi]),
            .init_mode  (init_reg[`CIO_INIT_FW*gi +: `CIO_INIT_FW]),
            .q          (el_q[gi])
         ); // [R5] [R6] [R7]
      end
   endgenerate

   // Input path
   assign user_in = ctrl_reg[`CIO_CTRL_IN_SEL] ?
                    el_q[`CIO_EL_IN] : pad_in; // [R8]

   // Output and enable paths, then polarity
   assign out_sel = ctrl_reg[`CIO_CTRL_OUT_SEL] ?
                    el_q[`CIO_EL_OUT] : user_out; // [R10]
   assign oe_sel  = ctrl_reg[`CIO_CTRL_OE_SEL] ?
                    el_q[`CIO_EL_OE] : user_oe; // [R11]
   assign drv_out = out_sel ^ inv_reg[`CIO_INV_OUT]; // [R1]
   assign drv_en  = oe_sel ^ inv_reg[`CIO_INV_OE]; // [R1]

   // Boundary scan: bit 0 pad in, bit 1 out data, bit 2 enable
   always @* begin
      bs_shift_next = bs_shift_reg;
      if (bs_capture) begin
         bs_shift_next = {drv_en, drv_out, pad_in}; // [R14]
      end else if (bs_shift) begin
         bs_shift_next = {bs_tdi,
                          bs_shift_reg[`CIO_BS_OE:`CIO_BS_OUT]}; // [R14]
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bs_shift_reg <= 3'h0;
         bs_hold_reg  <= 3'h0;
      end else begin
         bs_shift_reg <= bs_shift_next;
         if (bs_update) begin
            bs_hold_reg <= bs_shift_reg; // [R14]
         end
      end
   end
   assign bs_tdo = bs_shift_reg[`CIO_BS_PAD];

   // Unconfigured pins never drive, even under scan control
   assign drive_on = cfg_done &&
                     (bs_extest ? bs_hold_reg[`CIO_BS_OE] : drv_en); // [R2]
   assign pad_oe_n = !drive_on; // [R2]
   assign pad_out  = bs_extest ? bs_hold_reg[`CIO_BS_OUT] : drv_out; // [R14]

   // Pull-up from mode pins before configuration, pull-down off; both from register after
   assign pad_pullup   = cfg_done ? ctrl_reg[`CIO_CTRL_PULLUP]
                                  : mode_pullup; // [R4] [R13]
   assign pad_pulldown = cfg_done && ctrl_reg[`CIO_CTRL_PULLDN]; // [R3] [R13]

   // Keeper follows the pad, holds it once all drivers let go
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         keep_reg <= 1'b0;
      end else begin
         keep_reg <= pad_in; // [R12]
      end
   end
   assign pad_keep_en  = cfg_done && ctrl_reg[`CIO_CTRL_KEEP]; // [R3] [R12]
   assign pad_keep_val = keep_reg; // [R12]

   assign status = {drive_on, keep_reg, el_q, pad_in};

endmodule

// [tb/cio_sva.sv]
// Purpose: Port checker for the io cell
// Assumes: Tracks CTRL and INV writes on its own
// Notes:   Bound to cio_cell from tb_top
`timescale 1ns/1ps
`include "cio_map.vh"
module cio_sva (
   input logic        sys_clk,      // Clock
   input logic        rst,          // Reset
   input logic        psel,         // Select
   input logic        penable,      // Access
   input logic        pwrite,       // Write
   input logic [31:0] paddr,        // Address
   input logic [31:0] pwdata,       // Wdata
   input logic        pslverr,      // Error
   input logic        user_clk,     // Element clock
   input logic [2:0]  user_ce,      // Enables
   input logic        user_init,    // Init
   input logic        user_out,     // To pad
   input logic        user_oe,      // Drive
   input logic        user_in,      // From pad
   input logic        mode_pullup,  // Mode pin
   input logic        pad_in,       // Pad level
   input logic        pad_out,      // Drive level
   input logic        pad_oe_n,     // Drive off
   input logic        pad_pullup,   // Pull-up
   input logic        pad_pulldown, // Pull-down
   input logic        pad_keep_en,  // Keeper
   input logic        pad_keep_val, // Kept level
   input logic        bs_extest     // Scan owns pad
);
   logic [10:0] ctrl_reg;
   logic [6:0]  inv_reg;
   wire wr = psel && penable && pwrite;
   wire done = ctrl_reg[`CIO_CTRL_DONE];
   wire hit = paddr[31:4] == 28'h0 && paddr[1:0] == 2'h0;
   wire out_arm = done && ctrl_reg[2] && !ctrl_reg[9] && inv_reg == 7'h0
      && !bs_extest;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `CIO_CTRL_RST;
         inv_reg <= `CIO_INV_RST;
      end else if (wr && paddr == {28'h0, `CIO_ADDR_CTRL}) begin
         ctrl_reg <= pwdata[10:0];
      end else if (wr && paddr == {28'h0, `CIO_ADDR_INV}) begin
         inv_reg <= pwdata[6:0];
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_clk_low;
      out_arm && !user_clk;
   endsequence
   sequence s_out_load;
      s_clk_low ##1 (out_arm && user_clk && user_ce[1] && !user_init);
   endsequence
   a_precfg_hiz: assert property (!done |-> pad_oe_n
      && !pad_pulldown && !pad_keep_en)
      else $error("pad active before config");
   a_precfg_pull: assert property (!done |-> pad_pullup == mode_pullup)
      else $error("pre-config pull-up wrong");
   a_post_pulls: assert property (done |-> pad_pullup == ctrl_reg[5]
      && pad_pulldown == ctrl_reg[6] && pad_keep_en == ctrl_reg[7])
      else $error("pull selection wrong");
   a_keep_level: assert property (!$past(rst) |->
      pad_keep_val == $past(pad_in)) else $error("keeper level wrong");
   a_bad_addr: assert property (psel && penable |-> pslverr == !hit)
      else $error("slave error wrong");
   a_out_direct: assert property (done && !ctrl_reg[2]
      && !bs_extest |-> pad_out == (user_out ^ inv_reg[0]))
      else $error("direct out wrong");
   a_oe_direct: assert property (done && !ctrl_reg[3]
      && !bs_extest |-> pad_oe_n == !(user_oe ^ inv_reg[1]))
      else $error("direct oe wrong");
   a_in_direct: assert property (done && !ctrl_reg[1] |->
      user_in == pad_in) else $error("direct in wrong");
   a_flop_load: assert property (s_out_load |=> !out_arm || user_init
      || pad_out == $past(user_out)) else $error("flop load wrong");
endmodule

// [tb/cio_pad_model.sv]
// Purpose: Board side of the pad
// Assumes: Cell drive beats board drive, pulls beat keeper
// Notes:   Undriven pad wanders so a stale level never passes
`timescale 1ns/1ps
module cio_pad_model (
   input  logic sys_clk,      // Clock
   input  logic pad_out,      // Cell level
   input  logic pad_oe_n,     // Cell off
   input  logic pad_pullup,   // Pull-up
   input  logic pad_pulldown, // Pull-down
   input  logic pad_keep_en,  // Keeper
   input  logic pad_keep_val, // Kept level
   input  logic ext_en,       // Board drives
   input  logic ext_val,      // Board level
   output logic pad_lvl       // Resolved pad
);
   logic flt_reg = 1'h0;
   always @(posedge sys_clk) begin
      flt_reg <= !flt_reg;
   end
   assign pad_lvl = !pad_oe_n ? pad_out : ext_en ? ext_val :
      pad_pullup ? 1'h1 : pad_pulldown ? 1'h0 :
      pad_keep_en ? pad_keep_val : flt_reg;
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the io cell
// Assumes: APB slave answers whenever pready is seen
// Notes:   Scenarios run in order and share register state
`timescale 1ns/1ps
`include "cio_map.vh"
module tb_top;
   logic sys_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, user_clk = 1'h0, user_init = 1'h0;
   logic user_out = 1'h0, user_oe = 1'h0, mode_pullup = 1'h0;
   logic bs_extest = 1'h0, bs_capture = 1'h0, bs_shift = 1'h0;
   logic bs_update = 1'h0, bs_tdi = 1'h0, ext_en = 1'h0, ext_val = 1'h0;
   logic [2:0]  user_ce = 3'h0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, user_in, pad_in, pad_out, pad_oe_n, pad_pullup;
   wire pad_pulldown, pad_keep_en, pad_keep_val, bs_tdo;
   int n_errors = 0;
   int checks = 0;
   localparam logic [31:0] A_CTRL = {28'h0, `CIO_ADDR_CTRL};
   localparam logic [31:0] A_INIT = {28'h0, `CIO_ADDR_INIT};
   localparam logic [31:0] A_INV = {28'h0, `CIO_ADDR_INV};
   localparam logic [31:0] A_STAT = {28'h0, `CIO_ADDR_STATUS};
   always #25 sys_clk = ~sys_clk;
   cio_cell i_dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .user_clk, .user_ce,
      .user_init, .user_out, .user_oe, .user_in, .mode_pullup, .pad_in,
      .pad_out, .pad_oe_n, .pad_pullup, .pad_pulldown, .pad_keep_en,
      .pad_keep_val, .bs_extest, .bs_capture, .bs_shift, .bs_update,
      .bs_tdi, .bs_tdo);
   cio_pad_model i_pad (.sys_clk, .pad_out, .pad_oe_n, .pad_pullup,
      .pad_pulldown, .pad_keep_en, .pad_keep_val, .ext_en, .ext_val,
      .pad_lvl(pad_in));
   task stop_test;
      if (n_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int k;
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'h1 && k < 16);
      if (pready !== 1'h1) begin
         n_errors++;
         stop_test;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'h1, a, d, r, e);
      chk({31'h0, e}, 32'h0);
   endtask
   task rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'h0, a, 32'h0, r, e);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   // Clock low, rise with pad data flipped, then user data flips after the load edge
   task pulse(input logic [2:0] ce, input logic d);
      @(posedge sys_clk);
      user_ce <= ce;
      user_out <= d;
      ext_val <= d;
      user_clk <= 1'h0;
      @(posedge sys_clk);
      user_clk <= 1'h1;
      ext_val <= !d;
      @(posedge sys_clk);
      user_clk <= 1'h0;
      user_out <= !d;
      @(negedge sys_clk);
   endtask
   task t_regs;
      for (int i = 0; i < 12; i += 4) rd(i, 32'h0, 1'h0);
      wr(A_INV, 32'hffffffff);
      rd(A_INV, 32'h7f, 1'h0);
      wr(A_INV, 32'h0);
      wr(A_STAT, 32'hffffffff);
      rd(32'h10, 32'h0, 1'h1);
   endtask
   task t_precfg;
      wr(A_CTRL, 32'he0);
      user_oe <= 1'h1;
      for (int m = 0; m < 2; m++) begin
         mode_pullup <= m[0];
         @(negedge sys_clk);
         chk(pad_oe_n, 1'h1);
         chk({pad_pulldown, pad_keep_en}, 2'h0);
         chk(pad_pullup, m[0]);
         @(posedge sys_clk);
      end
   endtask
   task t_direct;
      wr(A_CTRL, 32'h1);
      for (int i = 0; i < 16; i++) begin
         wr(A_INV, {30'h0, i[3:2]});
         user_out <= i[0];
         user_oe <= i[1];
         @(negedge sys_clk);
         chk(pad_out, i[0] ^ i[2]);
         chk(pad_oe_n, !(i[1] ^ i[3]));
         if (i[1] ^ i[3]) chk(user_in, i[0] ^ i[2]);
      end
      wr(A_INV, 32'h0);
   endtask
   task t_flop;
      wr(A_CTRL, 32'h5);
      pulse(3'h2, 1'h0);
      chk(pad_out, 1'h0);
      pulse(3'h0, 1'h1);
      chk(pad_out, 1'h0);
      pulse(3'h2, 1'h1);
      chk(pad_out, 1'h1);
   endtask
   task t_latch;
      wr(A_CTRL, 32'h205);
      user_out <= 1'h1;
      user_clk <= 1'h1;
      repeat (2) @(posedge sys_clk);
      user_out <= 1'h0;
      @(negedge sys_clk);
      chk(pad_out, 1'h1);
      @(negedge sys_clk);
      chk(pad_out, 1'h0);
      @(posedge sys_clk);
      user_clk <= 1'h0;
      user_out <= 1'h1;
      repeat (3) @(negedge sys_clk);
      chk(pad_out, 1'h0);
   endtask
   task t_init;
      wr(A_CTRL, 32'h5);
      user_init <= 1'h1;
      pulse(3'h0, 1'h0);
      chk(pad_out, 1'h0);
      pulse(3'h2, 1'h0);
      chk(pad_out, 1'h1);
      @(posedge sys_clk);
      user_init <= 1'h0;
      wr(A_INIT, 32'hc);
      @(posedge sys_clk);
      user_init <= 1'h1;
      @(negedge sys_clk);
      chk(pad_out, 1'h0);
      @(posedge sys_clk);
      user_init <= 1'h0;
   endtask
   task t_input;
      ext_en <= 1'h1;
      user_oe <= 1'h0;
      wr(A_CTRL, 32'h13);
      pulse(3'h1, 1'h1);
      chk(user_in, 1'h1);
      wr(A_CTRL, 32'h3);
      pulse(3'h1, 1'h1);
      chk(user_in, 1'h0);
      wr(A_CTRL, 32'h1);
      ext_val <= 1'h1;
      @(negedge sys_clk);
      chk(user_in, 1'h1);
   endtask
   task t_pulls;
      for (int i = 0; i < 3; i++) begin
         wr(A_CTRL, (32'h20 << i) | 32'h1);
         @(negedge sys_clk);
         chk({pad_pullup, pad_pulldown, pad_keep_en}, 3'h4 >> i);
      end
      for (int v = 0; v < 2; v++) begin
         @(posedge sys_clk);
         ext_en <= 1'h1;
         ext_val <= v[0];
         repeat (2) @(posedge sys_clk);
         ext_en <= 1'h0;
         repeat (4) @(negedge sys_clk);
         chk({user_in, pad_keep_val}, {2{v[0]}});
      end
   endtask
   task t_scan;
      wr(A_CTRL, 32'h1);
      ext_en <= 1'h1;
      ext_val <= 1'h0;
      user_out <= 1'h1;
      bs_tdi <= 1'h1;
      bs_capture <= 1'h1;
      @(posedge sys_clk);
      bs_capture <= 1'h0;
      bs_shift <= 1'h1;
      for (int k = 0; k < 4; k++) begin
         @(negedge sys_clk);
         chk(bs_tdo, k[0]);
      end
      @(posedge sys_clk);
      bs_shift <= 1'h0;
      bs_update <= 1'h1;
      ext_en <= 1'h0;
      user_out <= 1'h0;
      @(posedge sys_clk);
      bs_update <= 1'h0;
      bs_extest <= 1'h1;
      @(negedge sys_clk);
      chk({pad_oe_n, pad_out}, 2'h1);
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      rst <= 1'h0;
      t_regs;
      t_precfg;
      t_direct;
      t_flop;
      t_latch;
      t_init;
      t_input;
      t_pulls;
      t_scan;
      stop_test;
   end
endmodule
bind cio_cell cio_sva i_sva (.sys_clk, .rst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pslverr, .user_clk, .user_ce, .user_init, .user_out,
   .user_oe, .user_in, .mode_pullup, .pad_in, .pad_out, .pad_oe_n,
   .pad_pullup, .pad_pulldown, .pad_keep_en, .pad_keep_val, .bs_extest);
